/* shared/rpn_cmd_pkg.sv */
// Package for the keypad command interpreter: command codes, widths, resets.
// Assumes one system clock and a command source that waits for ready.
package rpn_cmd_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned LEVELS = 5;
  localparam int unsigned LIST_DEPTH = 8;
  localparam int unsigned WFM_W = 8;
  localparam logic [WORD_W-1:0] LEVEL_RST = 32'h0000_0000;
  localparam logic [WFM_W-1:0] WFM_MAX_DEF = 8'h0F;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ALT_KEY_LATCH = 4'h1,
    CMD_ALT_KEY_CANCEL = 4'h2,
    CMD_CLEAR_ALL_LEVELS = 4'h3,
    CMD_CLEAR_TOP = 4'h4,
    CMD_ENTER = 4'h5,
    CMD_ROLL = 4'h6,
    CMD_SWAP_TOP_TWO = 4'h7,
    CMD_CLEAR_LIST = 4'h8,
    CMD_REMOVE_ONE = 4'h9,
    CMD_POINT_PLOT = 4'hA,
    CMD_SHOW_STORED = 4'hB,
    CMD_VECTOR_PLOT = 4'hC,
    CMD_DIGIT = 4'hD
  } cmd_t;

  typedef struct packed {
    cmd_t code;
    logic has_alt;
    cmd_t alt_code;
    logic [WORD_W-1:0] value;
  } cmd_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] level_one;
    logic [WORD_W-1:0] level_two;
    logic [WORD_W-1:0] level_three;
    logic [WORD_W-1:0] level_four;
    logic [WORD_W-1:0] level_five;
  } stack_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_t;

endpackage

/* rtl/rpn_stack_shift_display_list.sv */
// Command execution for the keypad front end: shift latch, five-level
// stack and display list of stored waveforms.
// Assumes a command source that holds a request until cmd_ready is high.
//
// Contract
// - Cancel clears shift latch, nothing else.
// - Alt key command sets shift latch.
// - Glyph shown exactly while latch set.
// - Any other command clears the latch.
// - Latched key runs alternate or nothing; latch and cancel keys run as themselves.
// - Latch keeps numeric entry on no-op.
// - Clear all levels writes zeros.
// - Clear top pops, level five kept.
// - Enter during entry only ends entry.
// - Roll rotates, level one to five.
// - Swap exchanges levels one and two.
// - Clear list empties shown-stored entries.
// - Remove one drops entry, pops stack.
// - Warn when removed entry was absent.
// - Point plot draws isolated dots.
// - Show stored adds entry, shows number.
// - List holds eight, duplicates ignored, full warns.
`timescale 1ns/10ps
module rpn_stack_shift_display_list #(
  parameter int unsigned LIST_N = rpn_cmd_pkg::LIST_DEPTH,
  parameter logic [rpn_cmd_pkg::WFM_W-1:0] WFM_MAX = rpn_cmd_pkg::WFM_MAX_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rpn_cmd_pkg::cmd_req_t cmd_req,
  output rpn_cmd_pkg::stack_t stack_out,
  output logic alt_active_glyph,
  output logic numeric_entry,
  output logic dot_mode,
  output logic [LIST_N-1:0] list_valid,
  output logic [LIST_N*rpn_cmd_pkg::WFM_W-1:0] list_wfm,
  output logic [rpn_cmd_pkg::WFM_W-1:0] shown_number,
  output logic shown_strobe,
  output logic warn
);

  // ****************************************************************
  // Parameter checks and state.
  // ****************************************************************
  if (LIST_N < 1 || LIST_N > 16)
  begin : g_chk
    $error("LIST_N out of range");
  end

  typedef struct packed {
    rpn_cmd_pkg::stack_t stk;
    logic alt;
    logic entry;
    logic dots;
    logic [LIST_N-1:0] vld;
    logic [LIST_N*rpn_cmd_pkg::WFM_W-1:0] wfm;
    logic [rpn_cmd_pkg::WFM_W-1:0] shown;
    logic shown_p;
    logic warn_p;
  } regs_t;

  regs_t r_q;
  regs_t r_d;
  rpn_cmd_pkg::cmd_t eff;
  logic [rpn_cmd_pkg::WFM_W-1:0] num;
  logic in_range;
  logic [LIST_N-1:0] hit;
  logic [LIST_N-1:0] free;
  logic [LIST_N-1:0] first_free;
  logic take;

  assign cmd_ready = 1'b1;
  assign take = cmd_valid & clk_en;

  // ****************************************************************
  // Key decode and list lookup.
  // ****************************************************************
  always_comb
  begin
    eff = rpn_cmd_pkg::CMD_NOP;
    if (!r_q.alt)
    begin
      eff = cmd_req.code;
    end
    else if (cmd_req.code == rpn_cmd_pkg::CMD_ALT_KEY_LATCH ||
             cmd_req.code == rpn_cmd_pkg::CMD_ALT_KEY_CANCEL)
    begin
      eff = cmd_req.code;
    end
    else if (cmd_req.has_alt)
    begin
      eff = cmd_req.alt_code;
    end
  end

  assign in_range = (r_q.stk.level_one <=
                     {{(rpn_cmd_pkg::WORD_W-rpn_cmd_pkg::WFM_W){1'b0}},
                      WFM_MAX});
  assign num = r_q.stk.level_one[rpn_cmd_pkg::WFM_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < LIST_N; gi++)
    begin : g_list
      assign hit[gi] = r_q.vld[gi] &&
        r_q.wfm[gi*rpn_cmd_pkg::WFM_W +: rpn_cmd_pkg::WFM_W] == num;
      assign free[gi] = ~r_q.vld[gi];
    end
  endgenerate

  assign first_free = free & (~free + {{(LIST_N-1){1'b0}}, 1'b1});

  // ****************************************************************
  // Command execution.
  // ****************************************************************
  always_comb
  begin
    r_d = r_q;
    r_d.shown_p = 1'b0;
    r_d.warn_p = 1'b0;
    if (take)
    begin
      r_d.alt = 1'b0;
      case (eff)
        rpn_cmd_pkg::CMD_ALT_KEY_LATCH:
        begin
          r_d.alt = 1'b1;
        end
        rpn_cmd_pkg::CMD_ALT_KEY_CANCEL:
        begin
          r_d.alt = 1'b0;
        end
        rpn_cmd_pkg::CMD_DIGIT:
        begin
          r_d.entry = 1'b1;
          r_d.stk.level_one = cmd_req.value;
        end
        rpn_cmd_pkg::CMD_CLEAR_ALL_LEVELS:
        begin
          r_d.stk = {rpn_cmd_pkg::LEVELS{rpn_cmd_pkg::LEVEL_RST}};
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_CLEAR_TOP:
        begin
          r_d.stk.level_one = r_q.stk.level_two;
          r_d.stk.level_two = r_q.stk.level_three;
          r_d.stk.level_three = r_q.stk.level_four;
          r_d.stk.level_four = r_q.stk.level_five;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_ENTER:
        begin
          if (r_q.entry)
          begin
            r_d.entry = 1'b0;
          end
          else
          begin
            r_d.stk.level_five = r_q.stk.level_four;
            r_d.stk.level_four = r_q.stk.level_three;
            r_d.stk.level_three = r_q.stk.level_two;
            r_d.stk.level_two = r_q.stk.level_one;
          end
        end
        rpn_cmd_pkg::CMD_ROLL:
        begin
          r_d.stk.level_one = r_q.stk.level_two;
          r_d.stk.level_two = r_q.stk.level_three;
          r_d.stk.level_three = r_q.stk.level_four;
          r_d.stk.level_four = r_q.stk.level_five;
          r_d.stk.level_five = r_q.stk.level_one;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_SWAP_TOP_TWO:
        begin
          r_d.stk.level_one = r_q.stk.level_two;
          r_d.stk.level_two = r_q.stk.level_one;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_CLEAR_LIST:
        begin
          r_d.vld = '0;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_POINT_PLOT:
        begin
          r_d.dots = 1'b1;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_VECTOR_PLOT:
        begin
          r_d.dots = 1'b0;
          r_d.entry = 1'b0;
        end
        rpn_cmd_pkg::CMD_REMOVE_ONE:
        begin
          r_d.entry = 1'b0;
          if (!in_range || hit == '0)
          begin
            r_d.warn_p = 1'b1;
          end
          else
          begin
            r_d.vld = r_q.vld & ~hit;
          end
          r_d.stk.level_one = r_q.stk.level_two;
          r_d.stk.level_two = r_q.stk.level_three;
          r_d.stk.level_three = r_q.stk.level_four;
          r_d.stk.level_four = r_q.stk.level_five;
        end
        rpn_cmd_pkg::CMD_SHOW_STORED:
        begin
          r_d.entry = 1'b0;
          if (!in_range || (hit == '0 && free == '0))
          begin
            r_d.warn_p = 1'b1;
          end
          else
          begin
            if (hit == '0)
            begin
              r_d.vld = r_q.vld | first_free;
              for (int k = 0; k < LIST_N; k++)
              begin
                if (first_free[k])
                begin
                  r_d.wfm[k*rpn_cmd_pkg::WFM_W +: rpn_cmd_pkg::WFM_W] = num;
                end
              end
            end
            r_d.shown = num;
            r_d.shown_p = 1'b1;
          end
          r_d.stk.level_one = r_q.stk.level_two;
          r_d.stk.level_two = r_q.stk.level_three;
          r_d.stk.level_three = r_q.stk.level_four;
          r_d.stk.level_four = r_q.stk.level_five;
        end
        default:
        begin
          r_d.alt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      r_q <= '0;
    end
    else if (clk_en)
    begin
      r_q <= r_d;
    end
  end

  assign stack_out = r_q.stk;
  assign alt_active_glyph = r_q.alt;
  assign numeric_entry = r_q.entry;
  assign dot_mode = r_q.dots;
  assign list_valid = r_q.vld;
  assign list_wfm = r_q.wfm;
  assign shown_number = r_q.shown;
  assign shown_strobe = r_q.shown_p;
  assign warn = r_q.warn_p;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_cancel;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cmd_req.code == rpn_cmd_pkg::CMD_ALT_KEY_CANCEL
    |=> !alt_active_glyph && $stable(stack_out);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel failed");

  property p_latch;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cmd_req.code == rpn_cmd_pkg::CMD_ALT_KEY_LATCH
    |=> alt_active_glyph;
  endproperty
  a_latch: assert property (p_latch) else $error("latch not set");

  property p_clear_latch;
    @(posedge clk_sys) disable iff (!rst_b)
    take && cmd_req.code != rpn_cmd_pkg::CMD_ALT_KEY_LATCH
    |=> !alt_active_glyph;
  endproperty
  a_clear_latch: assert property (p_clear_latch) else $error("latch held");

  property p_clr_all;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_CLEAR_ALL_LEVELS |=> stack_out == '0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("stack not zero");

  property p_roll;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_ROLL
    |=> stack_out.level_five == $past(stack_out.level_one);
  endproperty
  a_roll: assert property (p_roll) else $error("roll wrong");

  property p_swap;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_SWAP_TOP_TWO
    |=> stack_out.level_two == $past(stack_out.level_one) &&
        stack_out.level_three == $past(stack_out.level_three);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_push;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_ENTER && !numeric_entry
    |=> stack_out.level_two == $past(stack_out.level_one) &&
        stack_out.level_one == $past(stack_out.level_one);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_list_cap;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_SHOW_STORED && (&list_valid) &&
    hit == '0
    |=> warn && $stable(list_valid);
  endproperty
  a_list_cap: assert property (p_list_cap) else $error("full list");

  property p_pop;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_CLEAR_TOP
    |=> stack_out.level_one == $past(stack_out.level_two) &&
        stack_out.level_five == $past(stack_out.level_five);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_absent;
    @(posedge clk_sys) disable iff (!rst_b)
    take && eff == rpn_cmd_pkg::CMD_REMOVE_ONE && hit == '0
    |=> warn && $stable(list_valid);
  endproperty
  a_absent: assert property (p_absent) else $error("absent remove");

endmodule

/* tb/cmd_source.sv */
// Keypad command source model driving the interpreter's command port.
// Assumes the interpreter takes a command on the first rising edge.
`timescale 1ns/10ps
module cmd_source (
  input wire logic clk_sys,
  output logic cmd_valid,
  output rpn_cmd_pkg::cmd_req_t cmd_req
);
  // ************************************************************
  // Command issue
  // ************************************************************
  initial
  begin
    cmd_valid = 1'b0;
    cmd_req = '0;
  end

  // Waits idle+1 falling edges, then holds one command over one rising edge.
  // Operands for remove_one are supplied by the caller.
  task automatic issue(input rpn_cmd_pkg::cmd_t code, input logic alt,
    input rpn_cmd_pkg::cmd_t acode, input logic [31:0] val, input int idle);
    repeat (idle) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_req = '{code, alt, acode, val};
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_req = rpn_cmd_pkg::cmd_req_t'(~cmd_req);
  endtask
endmodule

/* tb/tb_top.sv */
// Testbench for the keypad command interpreter.
// Assumes the command source model and the interpreter package.
`timescale 1ns/10ps
module tb_top;
  // ************************************************************
  // Signals and stimulus table
  // ************************************************************
  typedef struct packed {
    logic [3:0] code;
    logic alt;
    logic [3:0] acode;
    logic [7:0] val;
    logic [39:0] stk;
    logic glyph;
    logic ent;
  } row_t;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_valid;
  logic cmd_ready;
  rpn_cmd_pkg::cmd_req_t cmd_req;
  rpn_cmd_pkg::stack_t stack_out;
  logic glyph;
  logic entry;
  logic dots;
  logic strobe;
  logic warn;
  logic [7:0] lv;
  logic [63:0] lw;
  logic [7:0] shown;
  int n_errors = 0;
  int checked = 0;
  row_t rows [27] = '{
    '{4'hD, 1'b0, 4'h0, 8'h05, 40'h0500000000, 1'b0, 1'b1},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0500000000, 1'b0, 1'b0},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0505000000, 1'b0, 1'b0},
    '{4'hD, 1'b0, 4'h0, 8'h04, 40'h0405000000, 1'b0, 1'b1},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0405000000, 1'b0, 1'b0},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0404050000, 1'b0, 1'b0},
    '{4'hD, 1'b0, 4'h0, 8'h03, 40'h0304050000, 1'b0, 1'b1},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0304050000, 1'b0, 1'b0},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0303040500, 1'b0, 1'b0},
    '{4'hD, 1'b0, 4'h0, 8'h02, 40'h0203040500, 1'b0, 1'b1},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0203040500, 1'b0, 1'b0},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0202030405, 1'b0, 1'b0},
    '{4'hD, 1'b0, 4'h0, 8'h01, 40'h0102030405, 1'b0, 1'b1},
    '{4'h6, 1'b0, 4'h0, 8'h00, 40'h0203040501, 1'b0, 1'b0},
    '{4'h7, 1'b0, 4'h0, 8'h00, 40'h0302040501, 1'b0, 1'b0},
    '{4'h4, 1'b0, 4'h0, 8'h00, 40'h0204050101, 1'b0, 1'b0},
    '{4'h5, 1'b0, 4'h0, 8'h00, 40'h0202040501, 1'b0, 1'b0},
    '{4'h1, 1'b0, 4'h0, 8'h00, 40'h0202040501, 1'b1, 1'b0},
    '{4'h4, 1'b0, 4'h0, 8'h00, 40'h0202040501, 1'b0, 1'b0},
    '{4'h1, 1'b0, 4'h0, 8'h00, 40'h0202040501, 1'b1, 1'b0},
    '{4'h1, 1'b0, 4'h0, 8'h00, 40'h0202040501, 1'b1, 1'b0},
    '{4'h7, 1'b1, 4'h6, 8'h00, 40'h0204050102, 1'b0, 1'b0},
    '{4'h1, 1'b0, 4'h0, 8'h00, 40'h0204050102, 1'b1, 1'b0},
    '{4'h2, 1'b0, 4'h0, 8'h00, 40'h0204050102, 1'b0, 1'b0},
    '{4'hD, 1'b0, 4'h0, 8'h07, 40'h0704050102, 1'b0, 1'b1},
    '{4'h1, 1'b0, 4'h0, 8'h00, 40'h0704050102, 1'b1, 1'b1},
    '{4'h4, 1'b0, 4'h0, 8'h00, 40'h0704050102, 1'b0, 1'b1}};

  always #2.5 clk_sys = ~clk_sys;

  cmd_source SRC (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_req(cmd_req));

  rpn_stack_shift_display_list DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_req(cmd_req), .stack_out(stack_out), .alt_active_glyph(glyph),
    .numeric_entry(entry), .dot_mode(dots), .list_valid(lv),
    .list_wfm(lw), .shown_number(shown), .shown_strobe(strobe),
    .warn(warn));

  // ************************************************************
  // Tasks and sequence
  // ************************************************************
  task automatic check(input string what, input logic [159:0] seen,
    input logic [159:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmd(input logic [3:0] c, input logic [7:0] v);
    SRC.issue(rpn_cmd_pkg::cmd_t'(c), 1'b0, rpn_cmd_pkg::CMD_NOP,
      {24'h000000, v}, 0);
  endtask

  function automatic logic has(input logic [7:0] n);
    has = 1'b0;
    for (int k = 0; k < 8; k++)
      if (lv[k] === 1'b1 && lw[k*8+:8] === n)
        has = 1'b1;
  endfunction

  function automatic logic [159:0] widen(input logic [39:0] b);
    widen = {24'h0, b[39:32], 24'h0, b[31:24], 24'h0, b[23:16],
      24'h0, b[15:8], 24'h0, b[7:0]};
  endfunction

  initial
  begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    check("reset stack", stack_out, '0);
    check("reset glyph", glyph, 1'b0);
    foreach (rows[i])
    begin
      SRC.issue(rpn_cmd_pkg::cmd_t'(rows[i].code), rows[i].alt,
        rpn_cmd_pkg::cmd_t'(rows[i].acode), {24'h0, rows[i].val}, i % 3);
      check("stack", stack_out, widen(rows[i].stk));
      check("glyph", glyph, rows[i].glyph);
      check("entry", entry, rows[i].ent);
    end
    cmd(4'h3, 8'h00);
    check("cleared stack", stack_out, '0);
    clk_en = 1'b0;
    cmd(4'hD, 8'h09);
    check("frozen", stack_out, '0);
    clk_en = 1'b1;
    for (int n = 1; n <= 8; n++)
    begin
      cmd(4'hD, n[7:0]);
      cmd(4'hB, 8'h00);
      check("shown", shown, n);
      check("strobe", strobe, 1'b1);
      check("added", has(n[7:0]), 1'b1);
      check("popped", stack_out.level_one, '0);
    end
    cmd(4'hD, 8'h03);
    cmd(4'hB, 8'h00);
    check("dup count", $countones(lv), 8);
    check("dup strobe", strobe, 1'b1);
    check("dup quiet", warn, 1'b0);
    cmd(4'hD, 8'h09);
    cmd(4'hB, 8'h00);
    check("full warn", warn, 1'b1);
    check("full list", has(8'h09), 1'b0);
    check("full strobe", strobe, 1'b0);
    cmd(4'hD, 8'h02);
    cmd(4'h9, 8'h00);
    check("removed", has(8'h02), 1'b0);
    check("remove count", $countones(lv), 7);
    check("remove pop", stack_out.level_one, '0);
    check("remove quiet", warn, 1'b0);
    cmd(4'hD, 8'h02);
    cmd(4'h9, 8'h00);
    check("absent warn", warn, 1'b1);
    SRC.issue(rpn_cmd_pkg::CMD_DIGIT, 1'b0, rpn_cmd_pkg::CMD_NOP,
      32'h0000_0103, 0);
    cmd(4'h9, 8'h00);
    check("range warn", warn, 1'b1);
    check("range list", $countones(lv), 7);
    check("range kept", has(8'h03), 1'b1);
    cmd(4'h8, 8'h00);
    check("list cleared", lv, 8'h00);
    cmd(4'hA, 8'h00);
    check("dots on", dots, 1'b1);
    cmd(4'hC, 8'h00);
    check("dots off", dots, 1'b0);
    cmd(4'h1, 8'h00);
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    check("mid reset glyph", glyph, 1'b0);
    end_of_test();
  end
endmodule
